// ### lmc_config_regs.sv
// configuration register set of the 48-channel led matrix driver
// Function
// R01 - three gain registers, channels interleaved by three
// R02 - gain value scales peak current linearly
// R03 - de-ghost enable gates four-bit pull-up level
// R04 - odd/even groups, phase bit delays 180 degrees
// R05 - host zeroes over-current select before retest
// R06 - over-current status reported once select written
// R07 - three-bit code picks pwm frequency, reset 100
// R08 - host avoids codes 000/001 in 6+2 mode
// R09 - host avoids slow codes with many lines
// R10 - scan rate equals pwm rate over lines
// R11 - spread enable and two-bit range
// R12 - de-ghost placement: 3/4, 1/2, slot end
// R13 - de-ghost duration, code 00 is 256ns
// R14 - open/short field: off, open, short
// R15 - mode 11 flags only, results untouched
// R16 - four-bit field selects tested scan line
// R17 - results hold only latest test type
// R18 - result bytes one bit per channel, reset zero
// R19 - six result bytes, readable after enable write
// R20 - host zeroes open/short enable before retest
// R21 - mode bit picks 6+2 or 8-bit column
// R22 - unused bits read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none
module lmc_config_regs #(
	parameter longint CLK_HZ = lmc_pkg::CLK_HZ_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic pwm_resolution_mode,
	input wire logic [3:0] scan_count_select,
	input wire logic oc_detect,
	input wire logic det_valid,
	input wire logic [lmc_pkg::CHANNELS-1:0] det_open,
	input wire logic [lmc_pkg::CHANNELS-1:0] det_short,
	output logic [lmc_pkg::CHANNELS*8-1:0] sink_scale,
	output logic [1:0] group_start,
	output logic [3:0] sink_pullup_level,
	output logic deghost_on,
	output logic deghost_strong,
	output logic [1:0] precharge_select,
	output logic spread_enable,
	output logic [1:0] spread_range,
	output logic oscillator_enable,
	output logic precision_boost_enable,
	output logic [3:0] scan_line,
	output logic test_line_active,
	output logic oc_fault,
	output logic open_fault,
	output logic short_fault
);
	import lmc_pkg::*;

	// -----------------------------------------------------------------
	// derived timing
	// -----------------------------------------------------------------
	localparam longint DEGHOST_BASE_CYC_L = (DEGHOST_BASE_NS * CLK_HZ + 64'd999_999_999)
		/ 64'd1_000_000_000;
	localparam logic [PER_W-1:0] DEGHOST_BASE_CYC =
		PER_W'(DEGHOST_BASE_CYC_L < 1 ? 1 : DEGHOST_BASE_CYC_L);

	function automatic lmc_tab8_t period_table(input bit eight_bit);
		lmc_tab8_t r;
		for (int i = 0; i < 8; i++) begin
			r[i] = int'(CLK_HZ / longint'(eight_bit ? FREQ8_HZ[i] : FREQ62_HZ[i]));
		end
		return r;
	endfunction

	localparam lmc_tab8_t PER8 = period_table(1'b1);
	localparam lmc_tab8_t PER62 = period_table(1'b0);

	// scan select code to number of active lines; no-scan codes count as one
	function automatic logic [3:0] lines_of(input logic [3:0] code);
		logic [3:0] n;
		n = 4'h1;
		if (code <= 4'h7) begin
			n = 4'h9 - code;
		end else if (code == 4'h9) begin
			n = 4'h4;
		end else if (code == 4'hA) begin
			n = 4'h3;
		end else if (code == 4'hB) begin
			n = 4'h2;
		end
		return n;
	endfunction

	// -----------------------------------------------------------------
	// register state
	// -----------------------------------------------------------------
	logic [7:0] gcc_reg [3];
	logic [7:0] gcc_next [3];
	logic [7:0] pullup_reg, pullup_next;
	logic [7:0] pwm_reg, pwm_next;
	logic [7:0] spread_reg, spread_next;
	logic [7:0] dgt_reg, dgt_next;
	logic [7:0] os_reg, os_next;
	logic [7:0] res_reg [RES_COUNT];
	logic [7:0] res_next [RES_COUNT];
	logic os_written_reg, os_written_next;
	logic oc_written_reg, oc_written_next;
	logic open_f_reg, open_f_next;
	logic short_f_reg, short_f_next;
	logic oc_f_reg, oc_f_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic signed [7:0] tri_reg, tri_next;
	logic up_reg, up_next;

	lmc_os_mode_t os_mode, os_mode_new;
	logic [3:0] test_line;
	logic [PER_W-1:0] base_period;
	logic signed [47:0] adj;
	logic [7:0] wmask;
	logic line_hit;

	lmc_timing_if tif ();

	lmc_scan_timer u_timer (
		.clk(clk),
		.rst(rst),
		.t(tif.tmr)
	);

	assign os_mode = lmc_os_mode_t'(os_reg[OS_MODE_LSB +: 2]);
	assign os_mode_new = lmc_os_mode_t'(reg_wdata[OS_MODE_LSB +: 2]);
	assign test_line = os_reg[OS_LINE_LSB +: 4];
	// line 1 is slot index 0
	assign line_hit = (test_line != 4'h0) && (tif.line_idx == test_line - 4'h1); // R16

	always_comb begin
		case (reg_addr)
			ADDR_PULLUP: wmask = MASK_PULLUP;
			ADDR_PWM: wmask = MASK_PWM;
			ADDR_SPREAD: wmask = MASK_SPREAD;
			ADDR_DGT: wmask = MASK_DGT;
			ADDR_OS: wmask = MASK_OS;
			default: wmask = 8'hFF;
		endcase
	end

	// -----------------------------------------------------------------
	// writes, detection capture and read-back
	// -----------------------------------------------------------------
	always_comb begin
		gcc_next = gcc_reg;
		pullup_next = pullup_reg;
		pwm_next = pwm_reg;
		spread_next = spread_reg;
		dgt_next = dgt_reg;
		os_next = os_reg;
		res_next = res_reg;
		os_written_next = os_written_reg;
		oc_written_next = oc_written_reg;
		open_f_next = open_f_reg;
		short_f_next = short_f_reg;
		oc_f_next = oc_written_reg & oc_detect; // R06
		rdata_next = rdata_reg;
		rvalid_next = reg_rd;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_GCC_RED: gcc_next[0] = reg_wdata; // R01
				ADDR_GCC_GREEN: gcc_next[1] = reg_wdata; // R01
				ADDR_GCC_BLUE: gcc_next[2] = reg_wdata; // R01
				ADDR_PULLUP: pullup_next = reg_wdata & wmask; // R22
				ADDR_PWM: begin
					pwm_next = reg_wdata & wmask; // R22
					oc_written_next = 1'b1;
				end
				ADDR_SPREAD: spread_next = reg_wdata & wmask; // R22
				ADDR_DGT: dgt_next = reg_wdata & wmask; // R22
				ADDR_OS: begin
					os_next = reg_wdata & wmask; // R22
					os_written_next = 1'b1;
					open_f_next = 1'b0;
					short_f_next = 1'b0;
					// switching between open and short drops the other set
					if ((os_mode_new == OS_OPEN || os_mode_new == OS_SHORT) && os_mode_new != os_mode) begin
						for (int i = 0; i < RES_COUNT; i++) begin
							res_next[i] = RST_RES; // R17
						end
					end
				end
				default: ;
			endcase
		end
		// a detection in the same cycle as the enable write is judged by the previous mode and test line
		if (det_valid && line_hit) begin
			case (os_mode)
				OS_OPEN: begin
					for (int i = 0; i < RES_COUNT; i++) begin
						res_next[i] = det_open[8*i +: 8]; // R14
					end
					open_f_next = open_f_next | (|det_open);
				end
				OS_SHORT: begin
					for (int i = 0; i < RES_COUNT; i++) begin
						res_next[i] = det_short[8*i +: 8]; // R14
					end
					short_f_next = short_f_next | (|det_short);
				end
				OS_SCAN: begin
					open_f_next = open_f_next | (|det_open); // R15
					short_f_next = short_f_next | (|det_short); // R15
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_GCC_RED: rdata_next = gcc_reg[0];
				ADDR_GCC_GREEN: rdata_next = gcc_reg[1];
				ADDR_GCC_BLUE: rdata_next = gcc_reg[2];
				ADDR_PULLUP: rdata_next = pullup_reg;
				ADDR_PWM: rdata_next = pwm_reg;
				ADDR_SPREAD: rdata_next = spread_reg;
				ADDR_DGT: rdata_next = dgt_reg;
				ADDR_OS: rdata_next = os_reg;
				default: begin
					rdata_next = 8'h00;
					if (reg_addr >= ADDR_RES_BASE && os_written_reg) begin
						rdata_next = res_reg[3'(reg_addr - ADDR_RES_BASE)]; // R19
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				gcc_reg[i] <= RST_GCC;
			end
			for (int i = 0; i < RES_COUNT; i++) begin
				res_reg[i] <= RST_RES; // R18
			end
			pullup_reg <= RST_PULLUP;
			pwm_reg <= RST_PWM; // R07
			spread_reg <= RST_SPREAD;
			dgt_reg <= RST_DGT;
			os_reg <= RST_OS;
			os_written_reg <= 1'b0;
			oc_written_reg <= 1'b0;
			open_f_reg <= 1'b0;
			short_f_reg <= 1'b0;
			oc_f_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			gcc_reg <= gcc_next;
			res_reg <= res_next;
			pullup_reg <= pullup_next;
			pwm_reg <= pwm_next;
			spread_reg <= spread_next;
			dgt_reg <= dgt_next;
			os_reg <= os_next;
			os_written_reg <= os_written_next;
			oc_written_reg <= oc_written_next;
			open_f_reg <= open_f_next;
			short_f_reg <= short_f_next;
			oc_f_reg <= oc_f_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// -----------------------------------------------------------------
	// pwm period with spread-spectrum sweep
	// -----------------------------------------------------------------
	// illegal codes for the current column are not blocked, only mapped to a legal rate
	assign base_period = pwm_resolution_mode ? PER_W'(PER8[pwm_reg[PFS_LSB +: 3]])
		: PER_W'(PER62[pwm_reg[PFS_LSB +: 3]]); // R07 R21

	// triangle of -64..63 steps once per period; adj = period*pct*tri/6400
	always_comb begin
		tri_next = tri_reg;
		up_next = up_reg;
		if (tif.pwm_start) begin
			if (up_reg) begin
				tri_next = tri_reg + 8'sh01;
				up_next = (tri_reg != 8'sh3E);
			end else begin
				tri_next = tri_reg - 8'sh01;
				up_next = (tri_reg == 8'shC1);
			end
		end
		adj = 48'sd0;
		if (spread_reg[SPREAD_ENABLE_BIT]) begin
			adj = (signed'({27'd0, base_period}) * signed'(48'(SPREAD_PCT[spread_reg[RNG_LSB +: 2]]))
				* 48'(tri_reg)) / 48'sd6400; // R11
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tri_reg <= 8'sh00;
			up_reg <= 1'b1;
		end else begin
			tri_reg <= tri_next;
			up_reg <= up_next;
		end
	end

	assign tif.period = PER_W'(signed'({27'd0, base_period}) + adj);
	assign tif.n_lines = lines_of(scan_count_select); // R10
	assign tif.dg_ref = lmc_dg_ref_t'(dgt_reg[DGREF_LSB +: 2]); // R12
	assign tif.dg_len = DEGHOST_BASE_CYC << dgt_reg[DGT_LSB +: 2]; // R13

	// -----------------------------------------------------------------
	// outputs to the sinks and switches
	// -----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_scale
			// channel ch+1 takes gain ch mod 3; peak = full * value / 256
			assign sink_scale[8*ch +: 8] = gcc_reg[ch % 3]; // R01 R02
		end
	endgenerate

	// group 0 is odd channels, group 1 even channels
	assign group_start[0] = tif.pwm_start; // R04
	assign group_start[1] = pwm_reg[PHC_BIT] ? tif.half_start : tif.pwm_start; // R04
	assign sink_pullup_level = pullup_reg[DEN_BIT] ? pullup_reg[PU_LEVEL_LSB +: 4] : 4'h0; // R03
	assign deghost_on = pullup_reg[DEN_BIT] & tif.dg_window; // R03
	assign deghost_strong = pullup_reg[DES_BIT];
	assign precharge_select = pullup_reg[PCS_LSB +: 2];
	assign spread_enable = spread_reg[SPREAD_ENABLE_BIT]; // R11
	assign spread_range = spread_reg[RNG_LSB +: 2]; // R11
	assign oscillator_enable = spread_reg[OSCILLATOR_ENABLE_BIT];
	assign precision_boost_enable = spread_reg[PRS_BIT];
	assign scan_line = tif.line_idx;
	assign test_line_active = (os_mode != OS_OFF) & line_hit;
	assign oc_fault = oc_f_reg; // R06
	assign open_fault = open_f_reg;
	assign short_fault = short_f_reg;
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
endmodule
`default_nettype wire

// ### lmc_pkg.sv
// constants, field layout and mode types of the led matrix configuration registers
package lmc_pkg;

	// -----------------------------------------------------------------
	// register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_GCC_RED = 8'hF1;
	localparam logic [7:0] ADDR_GCC_GREEN = 8'hF2;
	localparam logic [7:0] ADDR_GCC_BLUE = 8'hF3;
	localparam logic [7:0] ADDR_PULLUP = 8'hF5;
	localparam logic [7:0] ADDR_PWM = 8'hF6;
	localparam logic [7:0] ADDR_SPREAD = 8'hF7;
	localparam logic [7:0] ADDR_DGT = 8'hF8;
	localparam logic [7:0] ADDR_OS = 8'hF9;
	localparam logic [7:0] ADDR_RES_BASE = 8'hFA;
	localparam int RES_COUNT = 6;

	// -----------------------------------------------------------------
	// reset values and writable bit masks
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_GCC = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'h08;
	localparam logic [7:0] RST_PWM = 8'h04;
	localparam logic [7:0] RST_SPREAD = 8'hA0;
	localparam logic [7:0] RST_DGT = 8'h00;
	localparam logic [7:0] RST_OS = 8'h00;
	localparam logic [7:0] RST_RES = 8'h00;
	localparam logic [7:0] MASK_PULLUP = 8'hFF;
	localparam logic [7:0] MASK_PWM = 8'hB7;
	localparam logic [7:0] MASK_SPREAD = 8'hB3;
	localparam logic [7:0] MASK_DGT = 8'h0F;
	localparam logic [7:0] MASK_OS = 8'hCF;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int PU_LEVEL_LSB = 0;
	localparam int DEN_BIT = 4;
	localparam int DES_BIT = 5;
	localparam int PCS_LSB = 6;
	localparam int PFS_LSB = 0;
	localparam int OVERCURRENT_TEST_SELECT_LSB = 4;
	localparam int PHC_BIT = 7;
	localparam int RNG_LSB = 0;
	localparam int SPREAD_ENABLE_BIT = 4;
	localparam int OSCILLATOR_ENABLE_BIT = 5;
	localparam int PRS_BIT = 7;
	localparam int DGT_LSB = 0;
	localparam int DGREF_LSB = 2;
	localparam int OS_LINE_LSB = 0;
	localparam int OS_MODE_LSB = 6;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam longint CLK_HZ_DEF = 125_000_000;
	localparam longint DEGHOST_BASE_NS = 256;
	localparam int CHANNELS = 48;
	localparam int PER_W = 21;
	typedef int unsigned lmc_tab8_t [8];
	localparam lmc_tab8_t FREQ8_HZ = '{137000, 70000, 17600, 4400, 2200, 1100, 550, 275};
	// codes 000/001 are illegal in 6+2 mode; they fall back to the 010 rate
	localparam lmc_tab8_t FREQ62_HZ = '{66000, 66000, 66000, 16600, 8300, 4100, 2100, 1000};
	localparam int unsigned SPREAD_PCT [4] = '{5, 15, 20, 30};

	typedef enum logic [1:0] {
		OS_OFF = 2'b00,
		OS_OPEN = 2'b01,
		OS_SHORT = 2'b10,
		OS_SCAN = 2'b11
	} lmc_os_mode_t;

	typedef enum logic [1:0] {
		DG_THREE_Q = 2'b00,
		DG_HALF = 2'b01,
		DG_THREE_Q2 = 2'b10,
		DG_END = 2'b11
	} lmc_dg_ref_t;

endpackage

// ### lmc_timing_if.sv
// carrier between the configuration registers and the scan timer
`timescale 1ns/10ps
`default_nettype none
interface lmc_timing_if;
	import lmc_pkg::*;
	logic [PER_W-1:0] period;
	logic [3:0] n_lines;
	lmc_dg_ref_t dg_ref;
	logic [PER_W-1:0] dg_len;
	logic pwm_start;
	logic half_start;
	logic [3:0] line_idx;
	logic dg_window;
	modport cfg (output period, output n_lines, output dg_ref, output dg_len,
		input pwm_start, input half_start, input line_idx, input dg_window);
	modport tmr (input period, input n_lines, input dg_ref, input dg_len,
		output pwm_start, output half_start, output line_idx, output dg_window);
endinterface
`default_nettype wire

// ### lmc_scan_timer.sv
// pwm period counter, scan line stepping and de-ghost window
`timescale 1ns/10ps
`default_nettype none
module lmc_scan_timer (
	input wire logic clk,
	input wire logic rst,
	lmc_timing_if.tmr t
);
	import lmc_pkg::*;

	logic [PER_W-1:0] cnt_reg, cnt_next;
	logic [3:0] line_reg, line_next;
	logic [PER_W-1:0] dg_cnt_reg, dg_cnt_next;
	logic start_reg, start_next;
	logic half_reg, half_next;
	logic [PER_W-1:0] dg_at;

	// -----------------------------------------------------------------
	// one scan slot lasts one pwm period, so scan rate is pwm rate / n
	// -----------------------------------------------------------------
	always_comb begin
		case (t.dg_ref)
			DG_HALF: dg_at = t.period >> 1;
			DG_END: dg_at = (t.period > t.dg_len) ? t.period - t.dg_len : '0;
			default: dg_at = t.period - (t.period >> 2);
		endcase
		start_next = 1'b0;
		half_next = (cnt_reg == (t.period >> 1));
		cnt_next = cnt_reg + 1'b1;
		line_next = line_reg;
		dg_cnt_next = (dg_cnt_reg != '0) ? dg_cnt_reg - 1'b1 : '0;
		if (cnt_reg + 1'b1 >= t.period) begin
			cnt_next = '0;
			start_next = 1'b1;
			line_next = (line_reg + 1'b1 >= t.n_lines) ? 4'h0 : line_reg + 1'b1; // R10
		end
		if (cnt_reg == dg_at) begin
			dg_cnt_next = t.dg_len; // R12
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= '0;
			line_reg <= 4'h0;
			dg_cnt_reg <= '0;
			start_reg <= 1'b0;
			half_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			line_reg <= line_next;
			dg_cnt_reg <= dg_cnt_next;
			start_reg <= start_next;
			half_reg <= half_next;
		end
	end

	assign t.pwm_start = start_reg;
	assign t.half_start = half_reg;
	assign t.line_idx = line_reg;
	assign t.dg_window = (dg_cnt_reg != '0);
endmodule
`default_nettype wire

// ### lmc_config_regs_monitor.sv
// port-level assertion checker for the led matrix configuration registers
`timescale 1ns/10ps
`default_nettype none
module lmc_config_regs_monitor
	import lmc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic oc_detect,
	input wire logic det_valid,
	input wire logic [CHANNELS*8-1:0] sink_scale,
	input wire logic [3:0] sink_pullup_level,
	input wire logic [3:0] scan_line,
	input wire logic oc_fault,
	input wire logic open_fault,
	input wire logic short_fault
);
	logic [7:0] wd_reg;
	always_ff @(posedge clk) begin
		wd_reg <= reg_wdata;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	property p_gain_red;
		reg_wr && reg_addr == ADDR_GCC_RED |=> sink_scale[7:0] == wd_reg && sink_scale[31:24] == wd_reg;
	endproperty
	a_gain_red: assert property (p_gain_red) else $error("red gain not applied");
	property p_gain_green;
		reg_wr && reg_addr == ADDR_GCC_GREEN |=> sink_scale[15:8] == wd_reg
			&& sink_scale[375:368] == wd_reg;
	endproperty
	a_gain_green: assert property (p_gain_green) else $error("green gain not applied");
	property p_gain_blue;
		reg_wr && reg_addr == ADDR_GCC_BLUE |=> sink_scale[23:16] == wd_reg
			&& sink_scale[383:376] == wd_reg;
	endproperty
	a_gain_blue: assert property (p_gain_blue) else $error("blue gain not applied");
	property p_pullup;
		reg_wr && reg_addr == ADDR_PULLUP |=> sink_pullup_level == (wd_reg[4] ? wd_reg[3:0] : 4'h0);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up level wrong");
	property p_oc_report;
		reg_wr && reg_addr == ADDR_PWM ##1 oc_detect [*2] |=> oc_fault;
	endproperty
	a_oc_report: assert property (p_oc_report) else $error("over-current not reported");
	property p_oc_cause;
		oc_fault |-> $past(oc_detect);
	endproperty
	a_oc_cause: assert property (p_oc_cause) else $error("over-current flag without cause");
	property p_rvalid;
		reg_rd |=> reg_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_rvalid_cause;
		reg_rvalid |-> $past(reg_rd);
	endproperty
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
	property p_unused;
		reg_rd && reg_addr == ADDR_DGT |=> reg_rdata[7:4] == 4'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused timing bits not zero");
	property p_scan;
		$changed(scan_line) |-> scan_line == 4'h0 || scan_line == $past(scan_line) + 4'h1;
	endproperty
	a_scan: assert property (p_scan) else $error("scan line skipped");
	property p_clear;
		reg_wr && reg_addr == ADDR_OS && !det_valid |=> !open_fault && !short_fault;
	endproperty
	a_clear: assert property (p_clear) else $error("detect flags not cleared");
endmodule
bind lmc_config_regs lmc_config_regs_monitor i_lmc_config_regs_monitor (.*);
`default_nettype wire

// ### lmc_led_matrix_model.sv
// behavioural led matrix with switch transistors feeding the detectors
`timescale 1ns/10ps
`default_nettype none
module lmc_led_matrix_model
	import lmc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] scan_line,
	input wire logic [CHANNELS-1:0] open_mask,
	input wire logic [CHANNELS-1:0] short_mask,
	input wire logic oc_level,
	output logic det_valid,
	output logic [CHANNELS-1:0] det_open,
	output logic [CHANNELS-1:0] det_short,
	output logic oc_detect
);
	logic [3:0] line_reg;
	// ---------------------------------------------------------------
	// one detector result per scan slot
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		line_reg <= scan_line;
		det_valid <= !rst && scan_line != line_reg;
	end
	// data off the strobe is inverted so a mistimed capture cannot pass
	assign det_open = det_valid ? open_mask : ~open_mask;
	assign det_short = det_valid ? short_mask : ~short_mask;
	assign oc_detect = oc_level;
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking testbench for the led matrix configuration registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import lmc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic pwm_resolution_mode = 1'b1;
	logic [3:0] scan_count_select = 4'h0;
	logic oc_level = 1'b1;
	logic [CHANNELS-1:0] open_mask = '0;
	logic [CHANNELS-1:0] short_mask = '0;
	logic [7:0] reg_rdata;
	logic reg_rvalid, det_valid, oc_detect, deghost_on, deghost_strong, spread_enable;
	logic oscillator_enable, precision_boost_enable, test_line_active;
	logic oc_fault, open_fault, short_fault;
	logic [CHANNELS-1:0] det_open, det_short;
	logic [CHANNELS*8-1:0] sink_scale;
	logic [1:0] group_start, precharge_select, spread_range;
	logic [3:0] sink_pullup_level, scan_line;
	logic [7:0] sh [241:249];
	int fail_count = 0;
	int samples_checked = 0;
	int seed = 32'h4db3c033;
	// 1 MHz nominal keeps every pwm period short in simulation
	localparam longint SIM_HZ = 1_000_000;
	localparam int DG_CYC = int'((DEGHOST_BASE_NS * SIM_HZ + 999_999_999) / 1_000_000_000);
	lmc_config_regs #(.CLK_HZ(SIM_HZ)) i_lmc_config_regs (.*);
	lmc_led_matrix_model i_lmc_led_matrix_model (.*);
	always #4 clk = ~clk;
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] rstv(input logic [7:0] a);
		case (a)
			ADDR_PULLUP: return RST_PULLUP;
			ADDR_PWM: return RST_PWM;
			ADDR_SPREAD: return RST_SPREAD;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			ADDR_GCC_RED, ADDR_GCC_GREEN, ADDR_GCC_BLUE, ADDR_PULLUP: return 8'hFF;
			ADDR_PWM: return 8'hB7;
			ADDR_SPREAD: return 8'hB3;
			ADDR_DGT: return 8'h0F;
			ADDR_OS: return 8'hCF;
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
		samples_checked++;
		if (v !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	task automatic chk_fields();
		chk("pullup", sh[245][4] ? {4'h0, sh[245][3:0]} : 8'h00, {4'h0, sink_pullup_level});
		chk("drive", {5'h0, sh[245][7:5]}, {5'h0, precharge_select, deghost_strong});
		chk("spread", {3'h0, sh[247][7], sh[247][5:4], sh[247][1:0]},
			{3'h0, precision_boost_enable, oscillator_enable, spread_enable, spread_range});
		for (int c = 0; c < CHANNELS; c++)
			chk("gain", sh[241 + c % 3], sink_scale[8*c +: 8]);
	endtask
	task automatic run_test(input logic [7:0] code, input logic [CHANNELS-1:0] m);
		logic [7:0] d;
		int n;
		wr(ADDR_OS, code);
		n = 0;
		while (!(test_line_active === 1'b1 && det_valid === 1'b1) && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("detect wait", 8'h00, {7'h0, n >= 2000});
		for (int k = 0; k < RES_COUNT; k++) begin
			rd(ADDR_RES_BASE + 8'(k), d);
			chk("result", m[8*k +: 8], d);
		end
	endtask
	// the first interval after the write may be cut short, so the third is measured
	task automatic chk_period(input logic m, input logic [2:0] code);
		int n;
		pwm_resolution_mode = m;
		wr(ADDR_PWM, {5'h00, code});
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (group_start[0] !== 1'b1 && n < 2000);
		end
		chk("pwm period", 8'(SIM_HZ / longint'(m ? FREQ8_HZ[code] : FREQ62_HZ[code])), 8'(n));
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(8 * 60000);
		fail_count++;
		print_verdict();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] d;
		int a;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		for (a = 241; a <= 255; a++) begin
			rd(a[7:0], d);
			chk("reset value", rstv(a[7:0]), d);
		end
		chk("oc gated", 8'h00, {7'h0, oc_fault});
		oc_level = 1'b0;
		for (a = 241; a <= 249; a++)
			sh[a] = rstv(a[7:0]);
		for (int i = 0; i < 40; i++) begin
			a = 241 + int'($unsigned($random(seed)) % 8);
			d = 8'($random(seed));
			// keep the over-current test off and the slow rates out
			if (a == 246) d[5:4] = 2'b00;
			if (a == 246 && d[2:1] == 2'b11) d[1] = 1'b0;
			sh[a] = d & wmask(a[7:0]);
			wr(a[7:0], d);
			rd(a[7:0], d);
			chk("readback", sh[a], d);
			chk_fields();
		end
		wr(8'hFA, 8'h5A);
		rd(8'hFA, d);
		chk("read-only", 8'h00, d);
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_PWM, {p[0], 7'h00});
			a = 0;
			while (group_start[0] !== 1'b1 && a < 2000) begin
				@(negedge clk);
				a++;
			end
			chk("phase", {7'h0, ~p[0]}, {7'h0, group_start[1]});
		end
		oc_level = 1'b1;
		wr(ADDR_PWM, 8'h10);
		repeat (2) @(negedge clk);
		chk("oc", 8'h01, {7'h0, oc_fault});
		oc_level = 1'b0;
		repeat (2) @(negedge clk);
		chk("oc low", 8'h00, {7'h0, oc_fault});
		wr(ADDR_PWM, 8'h00);
		wr(ADDR_SPREAD, 8'h00);
		wr(ADDR_PULLUP, 8'h10);
		// de-ghost at half slot, time code 10
		wr(ADDR_DGT, 8'h06);
		chk_period(1'b1, 3'h3);
		chk_period(1'b0, 3'h2);
		a = 0;
		// four whole periods hold exactly four windows whatever the phase
		repeat (4 * (SIM_HZ / FREQ62_HZ[2])) begin
			@(negedge clk);
			if (deghost_on === 1'b1) a++;
		end
		chk("deghost cycles", 8'(4 * (DG_CYC << 2)), 8'(a));
		open_mask = CHANNELS'({$random(seed), $random(seed)});
		short_mask = CHANNELS'({$random(seed), $random(seed)});
		run_test(8'h41, open_mask);
		chk("open flag", {7'h0, |open_mask}, {7'h0, open_fault});
		wr(ADDR_OS, 8'h00);
		run_test(8'h89, short_mask);
		wr(ADDR_OS, 8'h00);
		open_mask = ~open_mask;
		run_test(8'hC3, short_mask);
		chk("short flag", {7'h0, |short_mask}, {7'h0, short_fault});
		chk("open flag", {7'h0, |open_mask}, {7'h0, open_fault});
		// three active lines: slot index never passes 2
		scan_count_select = 4'hA;
		while (scan_line !== 4'h0) @(negedge clk);
		a = 0;
		repeat (200) begin
			@(negedge clk);
			if (scan_line > a) a = scan_line;
		end
		chk("scan lines", 8'h02, 8'(a));
		print_verdict();
	end
endmodule
`default_nettype wire
